// [hdl/ueba_map.vh]
// Purpose: Register map, field positions and timing counts of the endpoint buffer access block
// Assumes: APB byte addresses, 32-bit words
// Notes:   Definitions only
`ifndef UEBA_MAP_VH
`define UEBA_MAP_VH

// Register byte addresses
`define UEBA_RX_DATA_ADDR   32'h4002_0018
`define UEBA_TX_DATA_ADDR   32'h4002_001C
`define UEBA_RX_LEN_ADDR    32'h4002_0020
`define UEBA_TX_LEN_ADDR    32'h4002_0024
`define UEBA_CTRL_ADDR      32'h4002_0028
`define UEBA_ROUTE_ADDR     32'h4002_002C

// transfer_control fields
`define UEBA_CTRL_RD_BIT    0
`define UEBA_CTRL_WR_BIT    1
`define UEBA_CTRL_EP_LSB    2
`define UEBA_CTRL_EP_MSB    5
`define UEBA_CTRL_RESET     6'h00

// Length counter fields
`define UEBA_LEN_MSB        9
`define UEBA_LEN_DV_BIT     10
`define UEBA_LEN_STEP       10'h004

// fast_route_select fields
`define UEBA_ROUTE_FRAME    0
`define UEBA_ROUTE_BULK_OUT_ROUTE  1
`define UEBA_ROUTE_BULK_IN_ROUTE   2
`define UEBA_ROUTE_ALL      3'h7
`define UEBA_ROUTE_RESET    3'h0

// Bulk routing applies to this logical endpoint only
`define UEBA_BULK_EP        4'h3

// Length fetch latency in clock cycles after a control write
`define UEBA_LEN_FETCH_CYC  3

`endif

// [hdl/ueba_ram.v]
// Purpose: Endpoint buffer RAM, single port, registered read data
// Assumes: One access per cycle
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ns
`default_nettype none

module ueba_ram #(
    parameter AW = 10,                     // Address width in words
    parameter DW = 32                      // Word width
) (
    input  wire          clock,            // Clock
    input  wire          we,               // Write strobe
    input  wire [AW-1:0] addr,             // Word address
    input  wire [DW-1:0] wdata,            // Write data
    output reg  [DW-1:0] rdata             // Registered read data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule // ueba_ram

`default_nettype wire

// [hdl/ueba_top.v]
// Purpose: Slave-mode endpoint buffer access and interrupt route select
// Assumes: APB slave at 125 MHz; engine side shares the clock and the RAM port
// Notes:   Buffer word 0 holds the packet length, data follow from word 1
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ueba_map.vh"

// What this block does
// - Read enable bit 0 lets the receive port read the selected OUT buffer.
// - Read enable clears itself once the packet's last word is read.
// - Write enable bit 1 lets transmit port writes fill the selected IN buffer.
// - Write enable clears itself once the programmed byte count is written.
// - Four-bit endpoint field in bits 5:2, reset 0, selects the buffer.
// - Enabling read loads the length first, then preloads the first word.
// - End of packet while reading raises the receive packet done flag.
// - Clearing read early aborts; next enable restarts from the first word.
// - Clearing write early makes the next session restart at the first data word, word 1.
// - Read and write may be enabled together on one endpoint.
// - Length fetch takes three cycles after the control write.
// - Set route bits send a source to the fast line, clear ones normal.
// - All route bits set routes nothing to the fast line.
// - Route bit 0 steers the frame tick interrupt.
// - Route bits 1 and 2 steer bulk out and in for endpoint 3.
// - Each transmit write lowers length by four; zero flags transmit done.
// - Receive words are little endian, first byte in the low byte.
module ueba_top #(
    parameter BUF_AW = 5                   // Word address width inside one buffer
) (
    input  wire                    clock,          // 125 MHz clock
    input  wire                    rst,            // Async reset, active high
    input  wire                    psel,           // APB select
    input  wire                    penable,        // APB enable
    input  wire                    pwrite,         // APB direction
    input  wire [31:0]             paddr,          // APB address
    input  wire [31:0]             pwdata,         // APB write data
    output reg  [31:0]             prdata,         // APB read data
    output wire                    pready,         // APB ready
    output wire                    pslverr,        // APB error, unmapped address
    input  wire                    engReq,         // Engine RAM request
    input  wire                    engWe,          // Engine RAM write
    input  wire [BUF_AW+4:0]       engAddr,        // Engine RAM word address
    input  wire [31:0]             engWdata,       // Engine RAM write data
    output wire [31:0]             engRdata,       // Engine RAM read data, next cycle
    output wire                    engGrant,       // Engine RAM access granted
    output reg                     rxPacketDone,   // Receive packet done pulse
    output reg                     txPacketDone,   // Transmit packet done pulse
    input  wire                    frameEvt,       // Frame tick interrupt source
    input  wire                    bulkOutEvt,     // Bulk out source, endpoint 3
    input  wire                    bulkInEvt,      // Bulk in source, endpoint 3
    output reg                     highPriorityLine, // Fast interrupt line
    output reg                     normalPriorityLine // Normal interrupt line
);

    localparam AW = BUF_AW + 5;
    localparam S_IDLE  = 2'b00;
    localparam S_LENRD = 2'b01;
    localparam S_LENGT = 2'b10;
    localparam S_WORD  = 2'b11;

    function [9:0] fnLess4;
        input [9:0] len;
        begin
            fnLess4 = (len > `UEBA_LEN_STEP) ? len - `UEBA_LEN_STEP : 10'h000;
        end
    endfunction

    function [AW-1:0] fnAddr;
        input           dirIn;
        input [3:0]     ep;
        input [BUF_AW-1:0] idx;
        begin
            fnAddr = {dirIn, ep, idx};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg              rdEn_q;
    reg              wrEn_q;
    reg  [3:0]       ep_q;
    reg  [2:0]       route_q;
    reg  [1:0]       state_q;
    reg  [9:0]       rxLen_q;
    reg              rxValid_q;
    reg  [31:0]      rxData_q;
    reg  [BUF_AW-1:0] rxIdx_q;
    reg  [9:0]       txLen_q;
    reg  [BUF_AW-1:0] txIdx_q;

    wire [31:0]      ramQ;
    reg              ramWe;
    reg  [AW-1:0]    ramAddr;
    reg  [31:0]      ramWd;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire selRxData = (paddr == `UEBA_RX_DATA_ADDR);
    wire selTxData = (paddr == `UEBA_TX_DATA_ADDR);
    wire selRxLen  = (paddr == `UEBA_RX_LEN_ADDR);
    wire selTxLen  = (paddr == `UEBA_TX_LEN_ADDR);
    wire selCtrl   = (paddr == `UEBA_CTRL_ADDR);
    wire selRoute  = (paddr == `UEBA_ROUTE_ADDR);
    wire mapped    = selRxData | selTxData | selRxLen | selTxLen | selCtrl | selRoute;

    // Accesses that need the RAM port wait for the fetch engine
    wire needRam   = (selRxData & ~pwrite) | ((selTxData | selTxLen) & pwrite);
    assign pready  = ~(needRam & (state_q != S_IDLE));
    assign pslverr = psel & penable & ~mapped;

    wire access    = psel & penable & pready;
    wire wrCtrl    = access & pwrite & selCtrl;
    wire newRdEn   = pwrite ? pwdata[`UEBA_CTRL_RD_BIT] : 1'b0;
    wire rdStart   = wrCtrl & newRdEn & ~rdEn_q;
    wire rdAbort   = wrCtrl & ~newRdEn;
    wire rxTake    = access & ~pwrite & selRxData & rdEn_q;
    wire rxLast    = rxTake & (rxLen_q <= `UEBA_LEN_STEP);
    wire txLenWr   = access & pwrite & selTxLen;
    wire txWr      = access & pwrite & selTxData & wrEn_q;
    wire txLast    = txWr & (txLen_q <= `UEBA_LEN_STEP);

    always @* begin
        if (selRxData) begin
            prdata = rxData_q;
        end else if (selRxLen) begin
            prdata = {21'h00_0000, rxValid_q, rxLen_q};
        end else if (selTxLen) begin
            prdata = {22'h00_0000, txLen_q};
        end else if (selCtrl) begin
            prdata = {26'h000_0000, ep_q, wrEn_q, rdEn_q};
        end else if (selRoute) begin
            prdata = {29'h000_0000, route_q};
        end else begin
            prdata = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM port mux, internal access first
    always @* begin
        ramWe   = 1'b0;
        ramWd   = pwdata;
        ramAddr = engAddr;
        if (state_q == S_LENRD) begin
            ramAddr = fnAddr(1'b0, ep_q, {BUF_AW{1'b0}});
        end else if (state_q == S_LENGT || rxTake) begin
            ramAddr = fnAddr(1'b0, ep_q, rxTake ? rxIdx_q + 1'b1 : rxIdx_q);
        end else if (txWr) begin
            ramWe   = 1'b1;
            ramAddr = fnAddr(1'b1, ep_q, txIdx_q);
        end else if (txLenWr) begin
            ramWe   = 1'b1;
            ramAddr = fnAddr(1'b1, ep_q, {BUF_AW{1'b0}});
            ramWd   = {22'h00_0000, pwdata[`UEBA_LEN_MSB:0]};
        end else if (engReq) begin
            ramWe   = engWe;
            ramWd   = engWdata;
        end
    end

    assign engGrant = engReq & (state_q == S_IDLE) & ~rxTake & ~txWr & ~txLenWr;
    assign engRdata = ramQ;

    ueba_ram #(
        .AW    (AW),
        .DW    (32)
    ) uRam (
        .clock (clock),
        .we    (ramWe),
        .addr  (ramAddr),
        .wdata (ramWd),
        .rdata (ramQ)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control and route registers, one owner for both enables
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdEn_q  <= 1'b0;
            wrEn_q  <= 1'b0;
            ep_q    <= 4'h0;
            route_q <= `UEBA_ROUTE_RESET;
        end else begin
            if (access & pwrite & selRoute) begin
                route_q <= pwdata[2:0];
            end
            if (wrCtrl) begin
                ep_q   <= pwdata[`UEBA_CTRL_EP_MSB:`UEBA_CTRL_EP_LSB];
                rdEn_q <= newRdEn;
                wrEn_q <= pwdata[`UEBA_CTRL_WR_BIT];
            end else begin
                // Hardware clears at end of packet
                if (rxLast) begin
                    rdEn_q <= 1'b0;
                end
                if (txLast) begin
                    wrEn_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive engine
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q      <= S_IDLE;
            rxLen_q      <= 10'h000;
            rxValid_q    <= 1'b0;
            rxData_q     <= 32'h0000_0000;
            rxIdx_q      <= {BUF_AW{1'b0}};
            rxPacketDone <= 1'b0;
        end else begin
            rxPacketDone <= 1'b0;
            if (rdAbort) begin
                state_q <= S_IDLE;
            end else if (rdStart) begin
                state_q <= S_LENRD;
                rxIdx_q <= {{(BUF_AW-1){1'b0}}, 1'b1};
            end else begin
                case (state_q)
                    S_LENRD: begin
                        state_q <= S_LENGT;
                    end
                    S_LENGT: begin
                        rxLen_q   <= ramQ[`UEBA_LEN_MSB:0];
                        rxValid_q <= ramQ[`UEBA_LEN_DV_BIT];
                        state_q   <= S_WORD;
                    end
                    S_WORD: begin
                        rxData_q <= ramQ;
                        state_q  <= S_IDLE;
                    end
                    default: begin
                        if (rxLast) begin
                            rxLen_q      <= 10'h000;
                            rxPacketDone <= 1'b1;
                        end else if (rxTake) begin
                            rxLen_q <= fnLess4(rxLen_q);
                            rxIdx_q <= rxIdx_q + 1'b1;
                            state_q <= S_WORD;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit engine
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            txLen_q      <= 10'h000;
            txIdx_q      <= {BUF_AW{1'b0}};
            txPacketDone <= 1'b0;
        end else begin
            txPacketDone <= 1'b0;
            if (wrCtrl & ~pwdata[`UEBA_CTRL_WR_BIT]) begin
                txIdx_q <= {{(BUF_AW-1){1'b0}}, 1'b1};
            end
            if (txLenWr) begin
                txLen_q <= pwdata[`UEBA_LEN_MSB:0];
                txIdx_q <= {{(BUF_AW-1){1'b0}}, 1'b1};
            end else if (txLast) begin
                txLen_q      <= 10'h000;
                txPacketDone <= 1'b1;
                txIdx_q      <= {{(BUF_AW-1){1'b0}}, 1'b1};
            end else if (txWr) begin
                txLen_q <= fnLess4(txLen_q);
                txIdx_q <= txIdx_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt routing
    always @* begin
        if (route_q == `UEBA_ROUTE_ALL) begin
            highPriorityLine   = 1'b0;
            normalPriorityLine = frameEvt | bulkOutEvt | bulkInEvt;
        end else begin
            highPriorityLine   = (route_q[`UEBA_ROUTE_FRAME] & frameEvt)
                               | (route_q[`UEBA_ROUTE_BULK_OUT_ROUTE] & bulkOutEvt)
                               | (route_q[`UEBA_ROUTE_BULK_IN_ROUTE] & bulkInEvt);
            normalPriorityLine = (~route_q[`UEBA_ROUTE_FRAME] & frameEvt)
                               | (~route_q[`UEBA_ROUTE_BULK_OUT_ROUTE] & bulkOutEvt)
                               | (~route_q[`UEBA_ROUTE_BULK_IN_ROUTE] & bulkInEvt);
        end
    end

endmodule // ueba_top

`default_nettype wire

// [bench/ueba_monitor.sv]
// Purpose: Port-level checker for the endpoint buffer access block
// Assumes: Single clock, async active-high reset
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
`include "ueba_map.vh"

module ueba_monitor (
    input wire logic        clock,              // Clock
    input wire logic        rst,                // Async reset
    input wire logic        psel,               // APB select
    input wire logic        penable,            // APB enable
    input wire logic        pwrite,             // APB direction
    input wire logic [31:0] paddr,              // APB address
    input wire logic [31:0] pwdata,             // APB write data
    input wire logic [31:0] prdata,             // APB read data
    input wire logic        pready,             // APB ready
    input wire logic        pslverr,            // APB error
    input wire logic        rxPacketDone,       // Receive done pulse
    input wire logic        txPacketDone,       // Transmit done pulse
    input wire logic        frameEvt,           // Frame source
    input wire logic        bulkOutEvt,         // Bulk out source
    input wire logic        bulkInEvt,          // Bulk in source
    input wire logic        highPriorityLine,   // Fast line
    input wire logic        normalPriorityLine  // Normal line
);
    logic [2:0] fastRoute_q;
    logic [2:0] fastSel;
    logic [2:0] srcs;
    logic       access, mapped, slowOp, rxTake, txTake;
    assign access = psel && penable;
    assign mapped = paddr == `UEBA_RX_DATA_ADDR || paddr == `UEBA_TX_DATA_ADDR || paddr == `UEBA_RX_LEN_ADDR
                 || paddr == `UEBA_TX_LEN_ADDR || paddr == `UEBA_CTRL_ADDR || paddr == `UEBA_ROUTE_ADDR;
    assign slowOp = pwrite ? (paddr == `UEBA_TX_DATA_ADDR || paddr == `UEBA_TX_LEN_ADDR)
                           : (paddr == `UEBA_RX_DATA_ADDR);
    assign rxTake = access && pready && !pwrite && paddr == `UEBA_RX_DATA_ADDR;
    assign txTake = access && pready && pwrite && paddr == `UEBA_TX_DATA_ADDR;
    assign fastSel = (fastRoute_q == `UEBA_ROUTE_ALL) ? 3'h0 : fastRoute_q;
    assign srcs = {bulkInEvt, bulkOutEvt, frameEvt};

    always @(posedge clock or posedge rst) begin
        if (rst)
            fastRoute_q <= `UEBA_ROUTE_RESET;
        else if (access && pready && pwrite && paddr == `UEBA_ROUTE_ADDR)
            fastRoute_q <= pwdata[2:0];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    fast_line_a: assert property (highPriorityLine == |(fastSel & srcs))
        else $error("fast line routing wrong");
    normal_line_a: assert property (normalPriorityLine == |(~fastSel & srcs))
        else $error("normal line routing wrong");
    err_unmapped_a: assert property (access && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (access && mapped |-> !pslverr)
        else $error("mapped access flagged");
    ready_plain_a: assert property (psel && !slowOp |-> pready)
        else $error("needless wait state");
    wait_bound_a: assert property (access && !pready |-> ##[1:4] pready)
        else $error("wait state too long");
    rx_pulse_a: assert property (rxPacketDone |=> !rxPacketDone)
        else $error("receive done longer than a cycle");
    rx_cause_a: assert property (rxPacketDone |-> $past(rxTake) || $past(rxTake, 2))
        else $error("receive done without read");
    tx_cause_a: assert property (txPacketDone |-> $past(txTake) || $past(txTake, 2))
        else $error("transmit done without write");

    cover property (rxPacketDone);
    cover property (txPacketDone);
    cover property (access && !pready);
endmodule // ueba_monitor

bind ueba_top ueba_monitor ueba_monitor_inst (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPacketDone(rxPacketDone),
    .txPacketDone(txPacketDone), .frameEvt(frameEvt), .bulkOutEvt(bulkOutEvt), .bulkInEvt(bulkInEvt),
    .highPriorityLine(highPriorityLine), .normalPriorityLine(normalPriorityLine)
);
`default_nettype wire

// [bench/ueba_top_tb.sv]
// Purpose: Self-checking bench for the endpoint buffer access block
// Assumes: APB master tasks, engine RAM port driven directly
// Notes:   Packets sit on logical endpoint 3
`timescale 1ns/1ns
`default_nettype none
`include "ueba_map.vh"

module ueba_top_tb;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, engWdata = 0, prdata, engRdata, rd;
    logic        engReq = 0, engWe = 0, frameEvt = 0, bulkOutEvt = 0, bulkInEvt = 0;
    logic [9:0]  engAddr = 0;
    logic        pready, pslverr, engGrant, rxPacketDone, txPacketDone, highPriorityLine, normalPriorityLine, er;
    logic        rxSeen_q = 0, txSeen_q = 0;
    int          bad_count = 0, check_count = 0;

    ueba_top ueba_top_inst (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .engReq(engReq),
        .engWe(engWe), .engAddr(engAddr), .engWdata(engWdata), .engRdata(engRdata), .engGrant(engGrant),
        .rxPacketDone(rxPacketDone), .txPacketDone(txPacketDone), .frameEvt(frameEvt),
        .bulkOutEvt(bulkOutEvt), .bulkInEvt(bulkInEvt), .highPriorityLine(highPriorityLine),
        .normalPriorityLine(normalPriorityLine)
    );

    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rxPacketDone === 1'b1) rxSeen_q <= 1'b1;
        if (txPacketDone === 1'b1) txSeen_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task eng(input logic we, input logic [4:0] idx, input logic [31:0] d, input logic inBuf);
        @(posedge clock);
        engReq   <= 1'b1;
        engWe    <= we;
        engAddr  <= {inBuf, `UEBA_BULK_EP, idx};
        engWdata <= d;
        @(posedge clock);
        while (engGrant !== 1'b1) @(posedge clock);
        engReq <= 1'b0;
        engWe  <= 1'b0;
        @(posedge clock);
        rd = engRdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        rst <= 0;
        rdc(`UEBA_CTRL_ADDR, 32'h0000_0000);
        rdc(`UEBA_ROUTE_ADDR, 32'h0000_0000);
        for (int v = 0; v < 8; v++) begin
            wr(`UEBA_ROUTE_ADDR, v);
            for (int s = 0; s < 3; s++) begin
                @(posedge clock);
                {bulkInEvt, bulkOutEvt, frameEvt} <= 3'h1 << s;
                @(negedge clock);
                chk(highPriorityLine, v != 7 && v[s]);
                chk(normalPriorityLine, !(v != 7 && v[s]));
            end
        end
        @(posedge clock);
        {bulkInEvt, bulkOutEvt, frameEvt} <= 3'h0;
        eng(1, 5'd0, 32'h0000_0408, 0);
        eng(1, 5'd1, 32'h4433_2211, 0);
        eng(1, 5'd2, 32'h8877_6655, 0);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000D);
        apb(0, `UEBA_RX_LEN_ADDR, 0);
        chk(rd & 32'h0000_07FF, 32'h0000_0408);
        rdc(`UEBA_RX_DATA_ADDR, 32'h4433_2211);
        apb(0, `UEBA_RX_LEN_ADDR, 0);
        chk(rd & 32'h0000_03FF, 32'h0000_0004);
        rdc(`UEBA_RX_DATA_ADDR, 32'h8877_6655);
        repeat (3) @(posedge clock);
        chk(rxSeen_q, 1'b1);
        rdc(`UEBA_CTRL_ADDR, 32'h0000_000C);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000D);
        rdc(`UEBA_RX_DATA_ADDR, 32'h4433_2211);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000C);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000F);
        rdc(`UEBA_CTRL_ADDR, 32'h0000_000F);
        rdc(`UEBA_RX_DATA_ADDR, 32'h4433_2211);
        wr(`UEBA_TX_LEN_ADDR, 32'h0000_0008);
        wr(`UEBA_TX_DATA_ADDR, 32'hA1A2_A3A4);
        rdc(`UEBA_TX_LEN_ADDR, 32'h0000_0004);
        wr(`UEBA_TX_DATA_ADDR, 32'hB1B2_B3B4);
        repeat (3) @(posedge clock);
        chk(txSeen_q, 1'b1);
        rdc(`UEBA_CTRL_ADDR, 32'h0000_000D);
        eng(0, 5'd1, 0, 1);
        chk(rd, 32'hA1A2_A3A4);
        eng(0, 5'd2, 0, 1);
        chk(rd, 32'hB1B2_B3B4);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000E);
        wr(`UEBA_TX_LEN_ADDR, 32'h0000_0008);
        wr(`UEBA_TX_DATA_ADDR, 32'hC1C2_C3C4);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000C);
        wr(`UEBA_CTRL_ADDR, 32'h0000_000E);
        wr(`UEBA_TX_LEN_ADDR, 32'h0000_0008);
        wr(`UEBA_TX_DATA_ADDR, 32'hD1D2_D3D4);
        eng(0, 5'd1, 0, 1);
        chk(rd, 32'hD1D2_D3D4);
        wr(`UEBA_TX_LEN_ADDR, 32'h0000_0000);
        wr(`UEBA_TX_DATA_ADDR, 32'hE1E2_E3E4);
        rdc(`UEBA_CTRL_ADDR, 32'h0000_000C);
        wr(`UEBA_TX_DATA_ADDR, 32'hF1F2_F3F4);
        eng(0, 5'd1, 0, 1);
        chk(rd, 32'hE1E2_E3E4);
        rdc(32'h4002_0030, 32'h0000_0000);
        chk(er, 1'b1);
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        stop_test;
    end
endmodule // ueba_top_tb
`default_nettype wire
